// *** iic_port.sv ***
// Two-wire serial port: slave engine, Start/Stop status for firmware masters, register slave.
// Assumes Avalon-MM with waitrequest on mclk and open-drain pins resolved outside with pull-ups.
`timescale 1ns/1ps
module iic_port import iic_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeN,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN
);
  typedef struct packed {
    logic waitReq;
    logic [DATA_W-1:0] rdata;
    logic [7:0] serialBuffer;
    logic [7:0] shiftReg;
    logic [7:0] slaveAddress;
    logic [7:0] portControl;
    logic [7:0] portStatus;
    logic [7:0] flagsOne;
    logic [7:0] enablesOne;
    logic [1:0] pinDir;
    iic_state_type state;
    logic [3:0] bitCnt;
    logic ackDrive;
    logic isAddr;
    logic goRead;
    logic uaPend;
    logic [1:0] tenStage;
    logic sclOeN;
    logic sdaOeN;
  } iic_port_state_type;

  iic_port_state_type s_r;
  iic_port_state_type s_nxt;
  iic_line_type lineSync;
  iic_event_type ev;

  iic_sync u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .lineAsync({sclIn, sdaIn}),
    .lineSync(lineSync)
  );

  iic_cond u_cond (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .lineSync(lineSync),
    .events(ev)
  );

  logic enabled;
  logic slaveOn;
  logic tenBit;
  logic spIrq;
  logic busReq;
  logic accept;
  logic wrLow;
  logic [7:0] wByte;
  logic full;
  logic hit;
  logic hiHit;
  logic moreAddr;
  logic readAddr;
  logic setUa;
  logic [1:0] tenNext;
  logic [7:0] rByte;

  always_comb begin
    s_nxt = s_r;
    enabled = s_r.portControl[CTRL_EN];
    tenBit = (s_r.portControl[3:0] == MODE_SLAVE10) || (s_r.portControl[3:0] == MODE_SLAVE10_SP);
    slaveOn = enabled && (tenBit || (s_r.portControl[3:0] == MODE_SLAVE7) ||
      (s_r.portControl[3:0] == MODE_SLAVE7_SP));
    spIrq = (s_r.portControl[3:0] == MODE_FIRMWARE) || (s_r.portControl[3:0] == MODE_SLAVE7_SP) ||
      (s_r.portControl[3:0] == MODE_SLAVE10_SP);
    busReq = avs_read || avs_write;
    accept = ce && busReq && !s_r.waitReq;
    wrLow = accept && avs_write && avs_byteenable[0];
    wByte = avs_writedata[7:0];
    full = s_r.portStatus[STAT_BF] || s_r.portControl[CTRL_OVF];
    hit = 1'b0;
    hiHit = 1'b0;
    moreAddr = 1'b0;
    readAddr = 1'b0;
    setUa = 1'b0;
    tenNext = TEN_NONE;
    rByte = BYTE_ZERO;

    if (ce) begin
      // Answer every request after exactly one wait cycle; read data stand with it.
      s_nxt.waitReq = !(busReq && s_r.waitReq);
      case (avs_address)
        OFS_BUFFER: rByte = s_r.serialBuffer;
        OFS_ADDRESS: rByte = s_r.slaveAddress;
        OFS_CONTROL: rByte = s_r.portControl;
        OFS_STATUS: rByte = s_r.portStatus;
        OFS_FLAGS: rByte = s_r.flagsOne;
        OFS_ENABLES: rByte = s_r.enablesOne;
        OFS_PINS: rByte = {4'h0, lineSync.scl, lineSync.sda, s_r.pinDir};
        default: rByte = BYTE_ZERO;
      endcase
      // Capture only when a read is taken, so the data hold until the next read.
      if (busReq && s_r.waitReq && avs_read) begin
        s_nxt.rdata = {24'h000000, rByte};
      end

      // Software side effects come first so that hardware sets below win.
      if (accept && avs_read && (avs_address == OFS_BUFFER)) begin
        s_nxt.portStatus[STAT_BF] = 1'b0;
      end
      if (wrLow) begin
        case (avs_address)
          OFS_BUFFER: begin
            if ((s_r.state == ST_TX) && s_r.portControl[CTRL_CKP]) begin
              s_nxt.portControl[CTRL_COL] = 1'b1;
            end else begin
              s_nxt.serialBuffer = wByte;
              if ((s_r.state != ST_RX) && (s_r.state != ST_ACK)) begin
                s_nxt.shiftReg = wByte;
              end
            end
          end
          OFS_ADDRESS: begin
            s_nxt.slaveAddress = wByte;
            s_nxt.portStatus[STAT_UA] = 1'b0;
          end
          OFS_CONTROL: s_nxt.portControl = wByte;
          OFS_FLAGS: s_nxt.flagsOne[FLAG_PORT] = wByte[FLAG_PORT];
          OFS_ENABLES: s_nxt.enablesOne = wByte;
          OFS_PINS: s_nxt.pinDir = wByte[1:0];
          default: s_nxt.enablesOne = s_r.enablesOne;
        endcase
      end

      if (ev.start) begin
        s_nxt.portStatus[STAT_START] = 1'b1;
        s_nxt.portStatus[STAT_STOP] = 1'b0;
      end
      if (ev.stop) begin
        s_nxt.portStatus[STAT_STOP] = 1'b1;
        s_nxt.portStatus[STAT_START] = 1'b0;
      end
      if (enabled && spIrq && (ev.start || ev.stop)) begin
        s_nxt.flagsOne[FLAG_PORT] = 1'b1;
      end

      case (s_r.state)
        ST_IDLE: begin
          s_nxt.ackDrive = 1'b0;
        end
        ST_RX: begin
          if (ev.sclRise) begin
            s_nxt.shiftReg = {s_r.shiftReg[6:0], lineSync.sda};
            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
          end
          if (ev.sclFall && (s_r.bitCnt == BYTE_BITS)) begin
            if (s_r.isAddr) begin
              hiHit = (s_r.shiftReg[7:3] == TEN_PREFIX) && (s_r.shiftReg[7:1] == s_r.slaveAddress[7:1]);
              if (!tenBit) begin
                hit = s_r.shiftReg[7:1] == s_r.slaveAddress[7:1];
                readAddr = s_r.shiftReg[0];
              end else if (s_r.tenStage == TEN_HIGH) begin
                hit = s_r.shiftReg == s_r.slaveAddress;
                setUa = hit;
                tenNext = hit ? TEN_FULL : TEN_NONE;
              end else if (hiHit && !s_r.shiftReg[0]) begin
                hit = 1'b1;
                setUa = 1'b1;
                moreAddr = 1'b1;
                tenNext = TEN_HIGH;
              end else if (hiHit && (s_r.tenStage == TEN_FULL)) begin
                hit = 1'b1;
                readAddr = 1'b1;
                tenNext = TEN_FULL;
              end
              if (hit) begin
                s_nxt.portStatus[STAT_RW] = readAddr;
                s_nxt.portStatus[STAT_DA] = 1'b0;
                s_nxt.tenStage = tenNext;
                s_nxt.isAddr = moreAddr;
                s_nxt.goRead = readAddr;
                s_nxt.uaPend = setUa;
                s_nxt.state = ST_ACK;
              end else begin
                s_nxt.tenStage = TEN_NONE;
                s_nxt.state = ST_IDLE;
              end
            end else begin
              s_nxt.portStatus[STAT_DA] = 1'b1;
              s_nxt.goRead = 1'b0;
              s_nxt.uaPend = 1'b0;
              s_nxt.state = ST_ACK;
              if (full) begin
                s_nxt.portControl[CTRL_OVF] = 1'b1;
              end
            end
            if ((hit || !s_r.isAddr) && !full) begin
              s_nxt.serialBuffer = s_r.shiftReg;
              s_nxt.portStatus[STAT_BF] = 1'b1;
              s_nxt.ackDrive = 1'b1;
            end else begin
              s_nxt.ackDrive = 1'b0;
            end
          end
        end
        ST_ACK: begin
          if (ev.sclFall) begin
            s_nxt.flagsOne[FLAG_PORT] = 1'b1;
            s_nxt.ackDrive = 1'b0;
            s_nxt.bitCnt = 4'h0;
            if (!s_r.ackDrive) begin
              s_nxt.state = ST_IDLE;
            end else if (s_r.goRead) begin
              s_nxt.portControl[CTRL_CKP] = 1'b0;
              s_nxt.state = ST_TX;
            end else begin
              s_nxt.state = ST_RX;
            end
            if (s_r.ackDrive && s_r.uaPend) begin
              s_nxt.portStatus[STAT_UA] = 1'b1;
            end
          end
        end
        ST_TX: begin
          if (ev.sclFall && s_r.portControl[CTRL_CKP]) begin
            s_nxt.shiftReg = {s_r.shiftReg[6:0], 1'b1};
            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
            if (s_r.bitCnt == LAST_TX_FALL) begin
              s_nxt.state = ST_TXACK;
            end
          end
        end
        ST_TXACK: begin
          if (ev.sclRise) begin
            s_nxt.goRead = !lineSync.sda;
          end
          if (ev.sclFall) begin
            s_nxt.flagsOne[FLAG_PORT] = 1'b1;
            s_nxt.bitCnt = 4'h0;
            if (s_r.goRead) begin
              s_nxt.portControl[CTRL_CKP] = 1'b0;
              s_nxt.state = ST_TX;
            end else begin
              s_nxt.state = ST_IDLE;
            end
          end
        end
        default: s_nxt.state = ST_IDLE;
      endcase

      // A Start restarts address reception from any state; a Stop drops the slave.
      if (ev.start && slaveOn) begin
        s_nxt.state = ST_RX;
        s_nxt.bitCnt = 4'h0;
        s_nxt.isAddr = 1'b1;
        s_nxt.ackDrive = 1'b0;
      end else if (ev.stop) begin
        s_nxt.state = ST_IDLE;
        s_nxt.tenStage = TEN_NONE;
        s_nxt.ackDrive = 1'b0;
      end

      if (!s_nxt.portControl[CTRL_EN]) begin
        s_nxt.portStatus[STAT_START] = 1'b0;
        s_nxt.portStatus[STAT_STOP] = 1'b0;
        s_nxt.portStatus[STAT_UA] = 1'b0;
        s_nxt.state = ST_IDLE;
        s_nxt.tenStage = TEN_NONE;
        s_nxt.ackDrive = 1'b0;
      end

      s_nxt.sclOeN = !(enabled && ((slaveOn && (!s_r.portControl[CTRL_CKP] || s_r.portStatus[STAT_UA])) ||
        !s_r.pinDir[0 + PIN_SCL_DIR]));
      // released data lets slave keep receiving
      s_nxt.sdaOeN = !(enabled && (s_r.ackDrive ||
        ((s_r.state == ST_TX) && s_r.portControl[CTRL_CKP] && !s_r.shiftReg[7]) ||
        !s_r.pinDir[PIN_SDA_DIR]));
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.waitReq <= 1'b1;
      s_r.portControl <= CONTROL_RST;
      s_r.pinDir <= PINS_RST[1:0];
      s_r.state <= ST_IDLE;
      s_r.sclOeN <= 1'b1;
      s_r.sdaOeN <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Open-drain: the output level is always low, only the enables move.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitReq;
  assign sclOeN = s_r.sclOeN;
  assign sdaOeN = s_r.sdaOeN;
endmodule

// *** iic_pkg.sv ***
// Constants, field layouts and carrier types shared by the two-wire serial port block.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus with byte addresses.
// Notes on behaviour
// - On address or data match with buffer and overflow clear, acknowledge and load buffer.
// - With buffer full or overflow set, no load, no acknowledge, interrupt flag still set.
// - Reading the buffer clears buffer-full; overflow stays until software clears it.
// - After enable wait for Start, then shift eight bits in on rising clock.
// - On the eighth falling clock compare shift bits seven to one with the address.
// - On match load buffer, set buffer-full, acknowledge, flag interrupt at ninth falling clock.
// - Ten-bit mode accepts high byte 11110 A9 A8 write, then receives the low byte.
// - Each ten-bit address byte sets flags and holds clock; address write releases it.
// - Matched address with direction clear clears status direction bit, address goes to buffer.
// - Interrupt flag set for every data byte and stays set until software clears it.
// - Matched address with direction set sets direction bit, acknowledges, then holds clock low.
// - Buffer write also loads shift register; setting clock-release lets transmission proceed.
// - Transmitter shifts eight bits out, changing data on falling clock edges.
// - Latch master acknowledge on ninth rising clock; not-acknowledge resets slave, await Start.
// - Start-seen and Stop-seen clear on reset or disable, else follow bus conditions.
// - Firmware master pins only ever drive low; a one is made by releasing.
// - Master-support modes flag interrupt on Start and Stop; 1110 and 1111 also flag each byte moved.
// - Mode 1011 gives Start and Stop interrupts with slave idle; the slave engine stays off.
// - Interrupt enabled while bus busy still sees an interrupt at the Stop.
// - Mode 0110 is seven-bit, 0111 ten-bit; 1110 and 1111 add Start and Stop interrupts.
package iic_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_BUFFER = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_ADDRESS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_ENABLES = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_PINS = 5'h18;

  localparam int CTRL_COL = 7;
  localparam int CTRL_OVF = 6;
  localparam int CTRL_EN = 5;
  localparam int CTRL_CKP = 4;
  localparam int STAT_DA = 5;
  localparam int STAT_STOP = 4;
  localparam int STAT_START = 3;
  localparam int STAT_RW = 2;
  localparam int STAT_UA = 1;
  localparam int STAT_BF = 0;
  localparam int FLAG_PORT = 3;
  localparam int PIN_SCL_DIR = 1;
  localparam int PIN_SDA_DIR = 0;
  localparam int PIN_SCL_LVL = 3;
  localparam int PIN_SDA_LVL = 2;

  localparam logic [3:0] MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] MODE_SLAVE10 = 4'h7;
  localparam logic [3:0] MODE_FIRMWARE = 4'hb;
  localparam logic [3:0] MODE_SLAVE7_SP = 4'he;
  localparam logic [3:0] MODE_SLAVE10_SP = 4'hf;

  localparam logic [4:0] TEN_PREFIX = 5'h1e;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_FALL = 4'h7;

  localparam logic [1:0] TEN_NONE = 2'h0;
  localparam logic [1:0] TEN_HIGH = 2'h1;
  localparam logic [1:0] TEN_FULL = 2'h2;

  localparam logic [7:0] CONTROL_RST = 8'h10;
  localparam logic [7:0] PINS_RST = 8'h03;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TXACK = 5'h10
  } iic_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } iic_line_type;

  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
  } iic_event_type;

endpackage

// *** iic_sync.sv ***
// Two-flop synchroniser for the bus lines.
// Assumes the inputs are asynchronous to mclk; only the second stage is read.
`timescale 1ns/1ps
module iic_sync import iic_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire iic_line_type lineAsync,
  output iic_line_type lineSync
);
  typedef struct packed {
    iic_line_type meta;
    iic_line_type stable;
  } iic_sync_state_type;

  iic_sync_state_type s_r;
  iic_sync_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (ce) begin
      s_nxt.meta = lineAsync;
      s_nxt.stable = s_r.meta;
    end
  end

  // Idle bus lines are high, so reset to the released level.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lineSync = s_r.stable;
endmodule

// *** iic_cond.sv ***
// Edge and bus condition detector working on synchronised lines.
// Assumes its input already passed the synchroniser; outputs are one-cycle pulses.
`timescale 1ns/1ps
module iic_cond import iic_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire iic_line_type lineSync,
  output iic_event_type events
);
  typedef struct packed {
    iic_line_type prev;
  } iic_cond_state_type;

  iic_cond_state_type s_r;
  iic_cond_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (ce) begin
      s_nxt.prev = lineSync;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    events.sclRise = ce && !s_r.prev.scl && lineSync.scl;
    events.sclFall = ce && s_r.prev.scl && !lineSync.scl;
    events.start = ce && s_r.prev.scl && lineSync.scl && s_r.prev.sda && !lineSync.sda;
    events.stop = ce && s_r.prev.scl && lineSync.scl && !s_r.prev.sda && lineSync.sda;
  end
endmodule

// *** iic_port_chk.sv ***
// Port-level assertions for the two-wire serial port.
// Assumes it is bound to iic_port with ce held high by the bench.
`timescale 1ns/1ps
module iic_port_chk import iic_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOeN,
  input wire logic sdaOut,
  input wire logic sdaOeN
);
  // Cycles since the last completed register write, saturating.
  logic [3:0] sinceWr_r;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sinceWr_r <= 4'hf;
    end else if (avs_write && !avs_waitrequest) begin
      sinceWr_r <= 4'h0;
    end else if (sinceWr_r != 4'hf) begin
      sinceWr_r <= sinceWr_r + 4'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  pins_drive_low_a: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("pin output level not low");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  read_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  read_hold_a: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
    else $error("read data changed outside an answer");
  data_stable_a: assert property (!sdaOeN && sclIn |=> !sdaOeN)
    else $error("data released while clock high");
  clock_release_a: assert property ($rose(sclOeN) |-> sinceWr_r < 4'h4)
    else $error("held clock released without a register write");
endmodule

// *** iic_bus_master.sv ***
// Behavioural two-wire bus master facing the port across pulled-up lines.
// Assumes the bench resolves the wired-AND levels and returns them on scl and sda.
`timescale 1ns/1ps
module iic_bus_master (
  input wire logic scl,
  input wire logic sda,
  output logic sclDrv,
  output logic sdaDrv
);
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic clkUp();
    int n;
    n = 0;
    sclDrv = 1'b1;
    while (scl !== 1'b1 && n < 4000) begin
      #40;
      n++;
    end
  endtask
  // Long low phase so the slave's delayed data settles before the rise.
  task automatic bitIo(input logic b, output logic s);
    #160;
    sdaDrv = b;
    #100;
    clkUp();
    #40;
    s = sda;
    #20;
    sclDrv = 1'b0;
  endtask
  task automatic startC();
    #160;
    sdaDrv = 1'b1;
    #100;
    clkUp();
    #160;
    sdaDrv = 1'b0;
    #160;
    sclDrv = 1'b0;
  endtask
  task automatic stopC();
    #160;
    sdaDrv = 1'b0;
    #100;
    clkUp();
    #160;
    sdaDrv = 1'b1;
    #320;
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(d[i], s);
    bitIo(1'b1, s);
    ack = ~s;
    #200;
  endtask
  task automatic rdByte(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, s);
      d[i] = s;
    end
    bitIo(~ackIt, s);
    #200;
  endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the two-wire serial port with a behavioural bus master.
// Assumes mclk at 25 MHz; the master model makes a 320 ns link clock.
`timescale 1ns/1ps
module tb import iic_pkg::*; ();
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest, sclOut, sclOeN, sdaOut, sdaOeN, mScl, mSda, ack;
  logic [7:0] q, q2, d, a7, hi;
  wire logic sclLine = mScl & (sclOeN | sclOut);
  wire logic sdaLine = mSda & (sdaOeN | sdaOut);
  int mismatches = 0;
  int total_checks = 0;
  always #20 mclk = ~mclk;
  iic_port iic_port_i (.mclk(mclk), .resetn(resetn), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sclIn(sclLine), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN));
  iic_bus_master iic_bus_master_i (.scl(sclLine), .sda(sdaLine), .sclDrv(mScl), .sdaDrv(mSda));
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd, input logic [3:0] be);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk(8'h00, 8'h01, "bus wait");
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] wd);
    bus(1'b1, a, wd, 4'hf);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string w, input logic [7:0] m = 8'hff);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(q & m, e, w);
  endtask
  function automatic logic [7:0] ctl(input logic [3:0] m);
    return {4'h3, m};
  endfunction
  function automatic logic [7:0] spFlag(input logic [3:0] m);
    return {4'h0, m == MODE_FIRMWARE || m == MODE_SLAVE7_SP || m == MODE_SLAVE10_SP, 3'h0};
  endfunction
  initial begin
    #1000000;
    mismatches++;
    stop_test();
  end
  initial begin
    logic [3:0] modes [5] = '{MODE_SLAVE7, MODE_SLAVE10, MODE_FIRMWARE, MODE_SLAVE7_SP, MODE_SLAVE10_SP};
    logic [7:0] pins [4] = '{8'h01, 8'h00, 8'h01, 8'h03};
    void'($urandom(16));
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd(OFS_CONTROL, CONTROL_RST, "ctl rst");
    rd(OFS_STATUS, 8'h00, "stat rst");
    rd(OFS_PINS, PINS_RST | 8'h0c, "pins rst");
    rd(5'h1c, 8'h00, "unmapped");
    d = 8'($urandom);
    wr(OFS_ENABLES, d);
    bus(1'b1, OFS_ENABLES, ~d, 4'he);
    rd(OFS_ENABLES, d, "enables");
    foreach (modes[i]) begin
      wr(OFS_CONTROL, ctl(modes[i]));
      wr(OFS_FLAGS, 8'h00);
      iic_bus_master_i.startC();
      rd(OFS_STATUS, 8'h08, "start seen", 8'h18);
      rd(OFS_FLAGS, spFlag(modes[i]), "start irq");
      wr(OFS_FLAGS, 8'h00);
      iic_bus_master_i.stopC();
      rd(OFS_STATUS, 8'h10, "stop seen", 8'h18);
      rd(OFS_FLAGS, spFlag(modes[i]), "stop irq");
      wr(OFS_CONTROL, 8'h00);
      rd(OFS_STATUS, 8'h00, "disable clears", 8'h18);
    end
    // bus idle with both bits clear, so firmware may drive.
    wr(OFS_CONTROL, ctl(MODE_FIRMWARE));
    foreach (pins[i]) begin
      wr(OFS_PINS, pins[i]);
      repeat (3) @(posedge mclk);
      rd(OFS_PINS, {4'h0, pins[i][1:0], pins[i][1:0]}, "pin levels");
      chk({6'h0, sclOeN, sdaOeN}, {6'h0, pins[i][1:0]}, "pin enables");
    end
    // firmware has released both lines; the slave engine still receives.
    a7 = 8'($urandom_range(119, 8));
    wr(OFS_ADDRESS, {a7[6:0], 1'b0});
    wr(OFS_CONTROL, ctl(MODE_SLAVE7));
    iic_bus_master_i.startC();
    iic_bus_master_i.wrByte({a7[6:0] ^ 7'h01, 1'b0}, ack);
    chk({7'h0, ack}, 8'h00, "foreign addr");
    iic_bus_master_i.startC();
    iic_bus_master_i.wrByte({a7[6:0], 1'b0}, ack);
    chk({7'h0, ack}, 8'h01, "addr ack");
    rd(OFS_STATUS, 8'h01, "addr status", 8'h27);
    rd(OFS_FLAGS, 8'h08, "addr flag");
    rd(OFS_BUFFER, {a7[6:0], 1'b0}, "addr buf");
    rd(OFS_STATUS, 8'h00, "full cleared", 8'h01);
    repeat (3) begin
      wr(OFS_FLAGS, 8'h00);
      d = 8'($urandom);
      iic_bus_master_i.wrByte(d, ack);
      chk({7'h0, ack}, 8'h01, "data ack");
      rd(OFS_FLAGS, 8'h08, "data flag");
      rd(OFS_BUFFER, d, "data buf");
    end
    d = 8'($urandom);
    iic_bus_master_i.wrByte(d, ack);
    wr(OFS_FLAGS, 8'h00);
    iic_bus_master_i.wrByte(~d, ack);
    chk({7'h0, ack}, 8'h00, "full no ack");
    rd(OFS_FLAGS, 8'h08, "refused flag");
    rd(OFS_CONTROL, 8'h76, "overflow set");
    rd(OFS_BUFFER, d, "buf kept");
    iic_bus_master_i.wrByte(d, ack);
    chk({7'h0, ack}, 8'h00, "ovf no ack");
    rd(OFS_CONTROL, 8'h76, "overflow stays");
    wr(OFS_CONTROL, ctl(MODE_SLAVE7));
    iic_bus_master_i.startC();
    iic_bus_master_i.wrByte({a7[6:0], 1'b1}, ack);
    chk({7'h0, ack}, 8'h01, "read addr ack");
    rd(OFS_STATUS, 8'h05, "read dir", 8'h07);
    rd(OFS_BUFFER, {a7[6:0], 1'b1}, "read addr buf");
    chk({7'h0, sclOeN}, 8'h00, "clock held");
    d = 8'($urandom);
    fork
      iic_bus_master_i.rdByte(1'b1, q2);
      begin
        #2000;
        wr(OFS_BUFFER, d);
        wr(OFS_CONTROL, ctl(MODE_SLAVE7));
      end
    join
    chk(q2, d, "tx byte");
    wr(OFS_BUFFER, ~d);
    wr(OFS_CONTROL, ctl(MODE_SLAVE7));
    wr(OFS_BUFFER, d);
    rd(OFS_CONTROL, 8'hb6, "collision");
    rd(OFS_BUFFER, ~d, "collision drop");
    wr(OFS_CONTROL, ctl(MODE_SLAVE7));
    iic_bus_master_i.rdByte(1'b0, q2);
    chk(q2, ~d, "last tx byte");
    chk({6'h0, sclOeN, sdaOeN}, 8'h03, "idle after nack");
    iic_bus_master_i.wrByte({a7[6:0], 1'b0}, ack);
    chk({7'h0, ack}, 8'h00, "no start no ack");
    iic_bus_master_i.stopC();
    hi = {TEN_PREFIX, 2'($urandom), 1'b0};
    d = 8'($urandom);
    wr(OFS_ADDRESS, hi);
    wr(OFS_CONTROL, ctl(MODE_SLAVE10));
    iic_bus_master_i.startC();
    iic_bus_master_i.wrByte(hi, ack);
    chk({7'h0, ack}, 8'h01, "high byte ack");
    rd(OFS_STATUS, 8'h03, "high update", 8'h07);
    chk({7'h0, sclOeN}, 8'h00, "update hold");
    wr(OFS_ADDRESS, d);
    rd(OFS_STATUS, 8'h01, "update cleared", 8'h07);
    rd(OFS_BUFFER, hi, "high buf");
    iic_bus_master_i.wrByte(d, ack);
    chk({7'h0, ack}, 8'h01, "low byte ack");
    rd(OFS_STATUS, 8'h03, "low update", 8'h07);
    wr(OFS_ADDRESS, hi);
    rd(OFS_BUFFER, d, "low buf");
    iic_bus_master_i.wrByte(~d, ack);
    chk({7'h0, ack}, 8'h01, "ten data ack");
    rd(OFS_BUFFER, ~d, "ten data buf");
    // repeated start and high byte again for a ten-bit read.
    iic_bus_master_i.startC();
    iic_bus_master_i.wrByte({hi[7:1], 1'b1}, ack);
    chk({7'h0, ack}, 8'h01, "ten read ack");
    rd(OFS_STATUS, 8'h05, "ten read status", 8'h07);
    wr(OFS_BUFFER, d);
    wr(OFS_CONTROL, ctl(MODE_SLAVE10));
    iic_bus_master_i.rdByte(1'b0, q2);
    chk(q2, d, "ten tx byte");
    iic_bus_master_i.stopC();
    stop_test();
  end
endmodule
bind iic_port iic_port_chk iic_port_chk_i (.mclk(mclk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sclIn(sclIn),
  .sclOut(sclOut), .sclOeN(sclOeN), .sdaOut(sdaOut), .sdaOeN(sdaOeN));
